/* design/smc_pkg.sv */
package smc_pkg;

  // ==========================================================================
  // register map
  localparam logic [7:0] SMC_CTRL_OFS    = 8'h00;
  localparam logic [7:0] SMC_STATUS_OFS  = 8'h04;
  localparam logic [7:0] SMC_ISTAT_OFS   = 8'h08;
  localparam logic [7:0] SMC_IMASK_OFS   = 8'h0c;
  localparam int         SMC_AW          = 8;

  // ==========================================================================
  // control register fields
  localparam int SMC_CTRL_W     = 11;
  localparam int SMC_C_MODE     = 0;
  localparam int SMC_C_SLEEP_EN = 2;
  localparam int SMC_C_EXT_EN   = 3;
  localparam int SMC_C_SENSE    = 4;
  localparam int SMC_C_ADC_EN   = 6;
  localparam int SMC_C_CMP_DIS  = 7;
  localparam int SMC_C_CMP_REF  = 8;
  localparam int SMC_C_WDT_EN   = 9;
  localparam int SMC_C_PC_EN    = 10;
  localparam logic [SMC_CTRL_W-1:0] SMC_CTRL_RST = 11'h000;

  // ==========================================================================
  // interrupt status bits
  localparam int SMC_IRQ_W       = 3;
  localparam int SMC_I_SLEPT     = 0;
  localparam int SMC_I_WOKE      = 1;
  localparam int SMC_I_ABORTED   = 2;

  // ==========================================================================
  // sleep modes and external line sensing
  localparam logic [1:0] SMC_MODE_IDLE = 2'h0;
  localparam logic [1:0] SMC_MODE_NR   = 2'h1;
  localparam logic [1:0] SMC_MODE_PD   = 2'h2;
  localparam logic [1:0] SMC_MODE_SB   = 2'h3;
  localparam logic [1:0] SMC_SENSE_LOW  = 2'h0;
  localparam logic [1:0] SMC_SENSE_ANY  = 2'h1;
  localparam logic [1:0] SMC_SENSE_FALL = 2'h2;

  // ==========================================================================
  // wake sources: ext level, ext edge, pin change, serial start, eeprom, adc, io
  localparam int              SMC_EV_W     = 7;
  localparam logic [6:0]      SMC_WAKE_IDLE = 7'h7f;
  localparam logic [6:0]      SMC_WAKE_NR   = 7'h3d;
  localparam logic [6:0]      SMC_WAKE_DEEP = 7'h0d;
  localparam logic [6:0]      SMC_EV_LEVEL  = 7'h01;

  // ==========================================================================
  // timing and fuses
  localparam int         SMC_SB_WAKE_CYC = 6;
  localparam logic [3:0] SMC_XTAL_SEL_MIN = 4'h8;
  localparam int         SMC_GATE_W = 5;

  typedef enum logic [1:0] {
    SMC_ACTIVE = 2'b00,
    SMC_SLEEP  = 2'b01,
    SMC_WAKE   = 2'b11
  } smc_state_e;

endpackage

/* design/smc_sleep_ctrl.sv */
// Summary of operation
// [R01] mode 11 with crystal source enters standby
// [R02] standby equals power-down, oscillator kept running
// [R03] standby wake resumes within six cycles
// [R04] waker holds level until wake completes
// [R05] vanished wake level skips its interrupt
// [R06] deep modes wake only on ext level sensing, pin change or serial start
// [R07] enabled converter stays enabled in sleep
// [R08] converter re-enable forces extended conversion
// [R09] comparator auto-off in power-down and standby
// [R10] comparator internal reference stays on in sleep
// [R11] fused brown-out detector runs in sleep
// [R12] enabled watchdog keeps running in sleep
// [R13] bandgap on only while a user needs it
// [R14] software waits bandgap start-up after re-enable
// [R15] input buffers off when io and converter clocks stop
// [R16] modes 00,01,10 select idle, noise-reduction, power-down
// [R17] power-down wake delayed by fuse start-up period
// [R18] standby gates all clocks but oscillator
module smc_sleep_ctrl
  import smc_pkg::*;
#(
  parameter int PD_BASE_CYC = 64,
  parameter int CNT_W       = 20,
  parameter int PC_W        = 11
) (
  input  wire logic                    pclk,
  input  wire logic                    presetn,
  input  wire logic                    psel,
  input  wire logic                    penable,
  input  wire logic                    pwrite,
  input  wire logic [smc_pkg::SMC_AW-1:0] paddr,
  input  wire logic [31:0]             pwdata,
  output logic      [31:0]             prdata,
  output logic                         pready,
  output logic                         pslverr,
  input  wire logic                    sleep_exec,
  input  wire logic                    brown_out_fuse_enable,
  input  wire logic [3:0]              clock_source_fuse_select,
  input  wire logic                    ext_irq_line_a,
  input  wire logic [PC_W-1:0]         pin_change_in,
  input  wire logic                    universal_serial_unit_start,
  input  wire logic                    eeprom_ready,
  input  wire logic                    converter_done,
  input  wire logic                    other_io_irq,
  input  wire logic                    converter_conv_start,
  output logic                         core_clock_en,
  output logic                         program_memory_clock_en,
  output logic                         peripheral_io_clock_en,
  output logic                         converter_clock_en,
  output logic                         main_osc_en,
  output logic                         input_buf_disable,
  output logic                         wake_buf_keep,
  output logic                         converter_power,
  output logic                         comparator_power,
  output logic                         bandgap_en,
  output logic                         brown_out_en,
  output logic                         watchdog_en,
  output logic                         extended_conv_next,
  output logic                         wake_irq_take,
  output logic                         irq
);
  import smc_pkg::*;

  // ==========================================================================
  // state
  typedef struct packed {
    smc_state_e             state;
    logic [1:0]             mode;
    logic                   lvl_only;
    logic [SMC_CTRL_W-1:0]  ctrl;
    logic [SMC_IRQ_W-1:0]   istat;
    logic [SMC_IRQ_W-1:0]   imask;
    logic [CNT_W-1:0]       cnt;
    logic                   ext_prev;
    logic [PC_W-1:0]        pc_prev;
    logic                   adc_prev;
    logic                   long_conv;
    logic [SMC_GATE_W-1:0]  gates;
    logic                   buf_off;
    logic                   buf_keep;
    logic                   adc_pwr;
    logic                   cmp_pwr;
    logic                   bg;
    logic                   bod;
    logic                   wdt;
    logic                   take;
    logic                   irq;
    logic [31:0]            rdata;
    logic                   rdy;
    logic                   err;
  } smc_state_s;

  smc_state_s q;
  smc_state_s d;

  logic            ext_s;
  logic [PC_W-1:0] pc_s;

  smc_sync #(.W(PC_W + 1)) u_sync (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in ({pin_change_in, ext_irq_line_a}),
    .sync_out ({pc_s, ext_s})
  );

  // ==========================================================================
  // decode helpers
  function automatic logic [SMC_EV_W-1:0] wake_allow(input logic [1:0] m);
    unique case (m)
      SMC_MODE_IDLE: wake_allow = SMC_WAKE_IDLE;
      SMC_MODE_NR:   wake_allow = SMC_WAKE_NR;
      default:       wake_allow = SMC_WAKE_DEEP;
    endcase
  endfunction

  // gates: {core, program memory, io, converter, oscillator}
  function automatic logic [SMC_GATE_W-1:0] gate_of(input smc_state_e s, input logic [1:0] m);
    if (s == SMC_ACTIVE) begin
      gate_of = 5'h1f;
    end else if (s == SMC_WAKE) begin
      gate_of = (m == SMC_MODE_IDLE) ? 5'h07 : (m == SMC_MODE_NR) ? 5'h03 : 5'h01;
    end else begin
      unique case (m)
        SMC_MODE_IDLE: gate_of = 5'h07;
        SMC_MODE_NR:   gate_of = 5'h03;
        SMC_MODE_SB:   gate_of = 5'h01;
        default:       gate_of = 5'h00;
      endcase
    end
  endfunction

  logic [SMC_EV_W-1:0] ev;
  logic                hit;
  logic                xtal;
  logic                acc;
  logic                setup;
  logic [SMC_IRQ_W-1:0] set_i;

  // ==========================================================================
  // next state
  always_comb begin
    d     = q;
    set_i = '0;
    xtal  = clock_source_fuse_select >= SMC_XTAL_SEL_MIN;
    setup = psel && !penable;
    acc   = psel && penable && q.rdy;
    ev[0] = q.ctrl[SMC_C_EXT_EN] && q.ctrl[SMC_C_SENSE +: 2] == SMC_SENSE_LOW && !ext_s;
    unique case (q.ctrl[SMC_C_SENSE +: 2])
      SMC_SENSE_ANY:  ev[1] = ext_s != q.ext_prev;
      SMC_SENSE_FALL: ev[1] = q.ext_prev && !ext_s;
      SMC_SENSE_LOW:  ev[1] = 1'b0;
      default:        ev[1] = !q.ext_prev && ext_s;
    endcase
    ev[1] = ev[1] && q.ctrl[SMC_C_EXT_EN];
    ev[2] = q.ctrl[SMC_C_PC_EN] && (pc_s != q.pc_prev);
    ev[3] = universal_serial_unit_start;
    ev[4] = eeprom_ready;
    ev[5] = converter_done;
    ev[6] = other_io_irq;
    hit   = |(ev & wake_allow(q.mode)); // R06
    d.ext_prev = ext_s;
    d.pc_prev  = pc_s;
    d.take     = 1'b0;

    unique case (q.state)
      SMC_ACTIVE: begin
        if (sleep_exec && q.ctrl[SMC_C_SLEEP_EN]) begin
          d.state = SMC_SLEEP; // R16
          d.mode  = q.ctrl[SMC_C_MODE +: 2];
          if (d.mode == SMC_MODE_SB && !xtal) begin
            d.mode = SMC_MODE_PD; // R01
          end
          set_i[SMC_I_SLEPT] = 1'b1;
        end
      end
      SMC_SLEEP: begin
        if (hit) begin
          d.state    = SMC_WAKE;
          d.lvl_only = (ev & wake_allow(q.mode)) == SMC_EV_LEVEL;
          if (q.mode == SMC_MODE_PD) begin
            d.cnt = CNT_W'((CNT_W'(PD_BASE_CYC) << clock_source_fuse_select[1:0]) - 1); // R17
          end else if (q.mode == SMC_MODE_SB) begin
            d.cnt = CNT_W'(SMC_SB_WAKE_CYC - 1); // R03
          end else begin
            d.cnt = '0;
          end
        end
      end
      SMC_WAKE: begin
        if (q.cnt == '0) begin
          d.state = SMC_ACTIVE;
          set_i[SMC_I_WOKE] = 1'b1;
          if (q.lvl_only && ext_s) begin
            set_i[SMC_I_ABORTED] = 1'b1; // R05
          end else begin
            d.take = 1'b1;
          end
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end
      default: d.state = SMC_ACTIVE;
    endcase

    // clock gating and analog helpers
    d.gates    = gate_of(d.state, d.mode); // R02 R18
    d.buf_off  = d.gates[2:1] == 2'b00; // R15
    d.buf_keep = d.buf_off && q.ctrl[SMC_C_EXT_EN];
    d.adc_pwr  = q.ctrl[SMC_C_ADC_EN]; // R07
    d.cmp_pwr  = !q.ctrl[SMC_C_CMP_DIS] &&
                 !(d.state != SMC_ACTIVE && d.mode[1]); // R09
    d.bod      = brown_out_fuse_enable; // R11
    d.wdt      = q.ctrl[SMC_C_WDT_EN]; // R12
    d.bg       = brown_out_fuse_enable || q.ctrl[SMC_C_ADC_EN] ||
                 (!q.ctrl[SMC_C_CMP_DIS] && q.ctrl[SMC_C_CMP_REF]); // R10 R13
    d.adc_prev = q.ctrl[SMC_C_ADC_EN];
    if (q.ctrl[SMC_C_ADC_EN] && !q.adc_prev) begin
      d.long_conv = 1'b1; // R08
    end else if (converter_conv_start) begin
      d.long_conv = 1'b0;
    end

    // apb slave, no wait states
    d.rdy = setup;
    if (setup) begin
      d.err = 1'b0;
      unique case (paddr)
        SMC_CTRL_OFS:   d.rdata = 32'(q.ctrl);
        SMC_STATUS_OFS: d.rdata = 32'({q.gates, q.bg, q.long_conv, q.state});
        SMC_ISTAT_OFS:  d.rdata = 32'(q.istat);
        SMC_IMASK_OFS:  d.rdata = 32'(q.imask);
        default: begin
          d.rdata = '0;
          d.err   = 1'b1;
        end
      endcase
    end else if (acc) begin
      d.rdata = '0;
      d.err   = 1'b0;
    end
    if (acc && pwrite) begin
      unique case (paddr)
        SMC_CTRL_OFS:  d.ctrl  = pwdata[SMC_CTRL_W-1:0];
        SMC_ISTAT_OFS: d.istat = q.istat & ~pwdata[SMC_IRQ_W-1:0];
        SMC_IMASK_OFS: d.imask = pwdata[SMC_IRQ_W-1:0];
        default:       d.ctrl  = q.ctrl;
      endcase
    end
    d.istat = d.istat | set_i;
    d.irq   = |(d.istat & d.imask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q       <= '0;
      q.state <= SMC_ACTIVE;
      q.ctrl  <= SMC_CTRL_RST;
      q.gates <= 5'h1f;
    end else begin
      q <= d;
    end
  end

  // ==========================================================================
  // outputs
  assign prdata                  = q.rdata;
  assign pready                  = q.rdy;
  assign pslverr                 = q.err;
  assign core_clock_en           = q.gates[4];
  assign program_memory_clock_en = q.gates[3];
  assign peripheral_io_clock_en  = q.gates[2];
  assign converter_clock_en      = q.gates[1];
  assign main_osc_en             = q.gates[0];
  assign input_buf_disable       = q.buf_off;
  assign wake_buf_keep           = q.buf_keep;
  assign converter_power         = q.adc_pwr;
  assign comparator_power        = q.cmp_pwr;
  assign bandgap_en              = q.bg;
  assign brown_out_en            = q.bod;
  assign watchdog_en             = q.wdt;
  assign extended_conv_next      = q.long_conv;
  assign wake_irq_take           = q.take;
  assign irq                     = q.irq;

  // ==========================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_SB_NEEDS_XTAL: assert property ( // R01
    (q.state == SMC_SLEEP && q.mode == SMC_MODE_SB) |-> xtal)
    else $error("standby without crystal source");
  AST_SB_OSC: assert property ( // R02
    (q.state == SMC_SLEEP && q.mode == SMC_MODE_SB) |-> main_osc_en && !core_clock_en)
    else $error("standby oscillator wrong");
  AST_SB_SIX: assert property ( // R03
    (q.state == SMC_SLEEP && q.mode == SMC_MODE_SB && hit) |=> (!core_clock_en) [*6] ##1 core_clock_en)
    else $error("standby wake not six cycles");
  AST_LVL_ABORT: assert property ( // R05
    (q.state == SMC_WAKE && q.cnt == '0 && q.lvl_only && ext_s) |=> !wake_irq_take)
    else $error("vanished wake serviced");
  AST_DEEP_NO_EDGE: assert property ( // R06
    (q.state == SMC_SLEEP && q.mode != SMC_MODE_IDLE && ev == 7'h02) |=> q.state == SMC_SLEEP)
    else $error("edge woke deep mode");
  AST_ADC_KEPT: assert property ( // R07
    $past(q.ctrl[SMC_C_ADC_EN]) |-> converter_power)
    else $error("converter dropped in sleep");
  AST_LONG_CONV: assert property ( // R08
    (q.ctrl[SMC_C_ADC_EN] && !q.adc_prev) |=> extended_conv_next)
    else $error("extended conversion not flagged");
  AST_CMP_OFF: assert property ( // R09
    (q.state == SMC_SLEEP && q.mode[1]) |-> !comparator_power)
    else $error("comparator on in deep sleep");
  AST_BANDGAP: assert property ( // R13
    ($past(!brown_out_fuse_enable) && !q.adc_prev && $past(q.ctrl[SMC_C_CMP_DIS]))
      |-> !bandgap_en)
    else $error("bandgap on with no user");
  AST_BUF_OFF: assert property ( // R15
    (q.state == SMC_SLEEP && q.mode[1]) |-> input_buf_disable)
    else $error("input buffers left on");
  AST_PD_DELAY: assert property ( // R17
    (q.state == SMC_SLEEP && q.mode == SMC_MODE_PD && hit) |=> (!core_clock_en) [*2])
    else $error("power-down woke too early");

endmodule

/* design/smc_sync.sv */
module smc_sync #(
  parameter int W = 1
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  // ==========================================================================
  // two flop synchroniser per bit
  for (genvar i = 0; i < W; i++) begin : g_bit
    logic meta_q;
    logic sync_q;
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        meta_q <= 1'b0;
        sync_q <= 1'b0;
      end else begin
        meta_q <= async_in[i];
        sync_q <= meta_q;
      end
    end
    assign sync_out[i] = sync_q;
  end

endmodule

/* test/smc_core_model.sv */
// =========
// core side: issues sleep, counts served wakes
module smc_core_model (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic       go,
  input  wire logic       core_clock_en,
  input  wire logic       wake_irq_take,
  output logic            sleep_exec,
  output logic      [7:0] taken
);
  timeunit 1ns;
  timeprecision 1ps;

  // sleep only issues while the core clock runs
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sleep_exec <= 1'b0;
      taken      <= 8'h00;
    end else begin
      sleep_exec <= go && core_clock_en;
      if (wake_irq_take) begin
        taken <= taken + 8'h01;
      end
    end
  end
endmodule

/* test/tb.sv */
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import smc_pkg::*;

  // =========
  // signals
  localparam int PDB     = 2;
  localparam int BG_WAIT = 2800;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd;
  logic        pready, pslverr, err, sleep_exec;
  logic        sleep_go = 1'b0;
  logic        brown_out_fuse_enable = 1'b1;
  logic [3:0]  clock_source_fuse_select = 4'h8;
  logic        ext_irq_line_a = 1'b1;
  logic [10:0] pin_change_in = 11'h000;
  logic        universal_serial_unit_start = 1'b0;
  logic        converter_conv_start = 1'b0;
  logic        eeprom_ready = 1'b0;
  logic        converter_done = 1'b0;
  logic        other_io_irq = 1'b0;
  logic        core_clock_en, program_memory_clock_en, peripheral_io_clock_en, converter_clock_en;
  logic        main_osc_en, input_buf_disable, wake_buf_keep, converter_power, comparator_power;
  logic        bandgap_en, brown_out_en, watchdog_en, extended_conv_next, wake_irq_take, irq;
  logic [7:0]  taken;
  logic [4:0]  gates;
  int          bad_count = 0;
  int          compares = 0;

  assign gates = {core_clock_en, program_memory_clock_en, peripheral_io_clock_en, converter_clock_en, main_osc_en};
  always #12.5 pclk = ~pclk;

  smc_sleep_ctrl #(.PD_BASE_CYC(PDB)) u_dut (.*);
  smc_core_model u_core (.*, .go(sleep_go));

  // =========
  // helpers
  task automatic finish_test();
    if (bad_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask

  task automatic ck(input logic ok, input string m);
    compares++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("FAIL %0t %s", $time, m);
    end
  endtask

  task automatic tmo(input logic hit);
    if (hit) begin
      ck(1'b0, "wait timed out");
      finish_test();
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    tmo(n >= 50);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic wait_core(output int n);
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (core_clock_en !== 1'b1 && n < 100);
    tmo(n >= 100);
  endtask

  task automatic enter(input logic [1:0] m, input logic [3:0] f, input logic [10:0] cf);
    clock_source_fuse_select <= f;
    wr(SMC_CTRL_OFS, 32'(cf) | 32'(m) | 32'h4);
    @(posedge pclk);
    sleep_go <= 1'b1;
    @(posedge pclk);
    sleep_go <= 1'b0;
    repeat (3) @(posedge pclk);
  endtask

  task automatic wake_ext(output int n);
    ext_irq_line_a <= 1'b0;
    wait_core(n);
    @(posedge pclk);
    ext_irq_line_a <= 1'b1;
  endtask

  task automatic conv_pulse();
    @(posedge pclk);
    converter_conv_start <= 1'b1;
    @(posedge pclk);
    converter_conv_start <= 1'b0;
  endtask

  // =========
  // scenarios
  task automatic t_reset();
    logic [7:0]  a[5];
    logic [31:0] e[5];
    a = '{SMC_CTRL_OFS, SMC_STATUS_OFS, SMC_ISTAT_OFS, SMC_IMASK_OFS, 8'h10};
    e = '{32'h0, 32'h1f8, 32'h0, 32'h0, 32'h0};
    ck(gates === 5'h1f && irq === 1'b0, "reset gates");
    ck({converter_power, comparator_power, watchdog_en, wake_irq_take} === 4'h0, "reset outputs");
    foreach (a[i]) begin
      apb(1'b0, a[i], 32'h0);
      ck(rd === e[i] && err === (i == 4), "reset value");
    end
    wr(SMC_CTRL_OFS, 32'hffffffff);
    apb(1'b0, SMC_CTRL_OFS, 32'h0);
    ck(rd === 32'h7ff, "control width");
    wr(8'h10, 32'h1);
    ck(err === 1'b1, "unmapped write");
  endtask

  task automatic t_modes();
    logic [4:0] eg[4];
    logic [7:0] t0;
    int         d[4];
    eg = '{5'h07, 5'h03, 5'h00, 5'h01};
    t0 = taken;
    for (int m = 0; m < 4; m++) begin
      enter(2'(m), 4'h8, 11'h248);
      ck(gates === eg[m], "sleep clock gates");
      ck(input_buf_disable === (m >= 2), "input buffers");
      ck(wake_buf_keep === (m >= 2), "wake pin buffer");
      ck(comparator_power === (m < 2), "comparator power");
      ck({converter_power, watchdog_en, brown_out_en} === 3'h7, "helpers in sleep");
      wake_ext(d[m]);
    end
    ck(d[3] - d[0] == 5 && d[1] == d[0], "standby wake latency");
    ck(taken === t0 + 8'h04, "wake interrupt served");
  endtask

  task automatic t_conv();
    int n;
    brown_out_fuse_enable <= 1'b0;
    conv_pulse();
    wr(SMC_CTRL_OFS, 32'h080);
    repeat (3) @(posedge pclk);
    ck(bandgap_en === 1'b0, "bandgap unused");
    wr(SMC_CTRL_OFS, 32'h040);
    repeat (3) @(posedge pclk);
    ck(bandgap_en === 1'b1 && extended_conv_next === 1'b1, "converter re-enabled");
    repeat (BG_WAIT) @(posedge pclk);
    conv_pulse();
    repeat (2) @(posedge pclk);
    ck(extended_conv_next === 1'b0, "extended conversion done");
    enter(SMC_MODE_PD, 4'h8, 11'h108);
    ck(bandgap_en === 1'b1 && brown_out_en === 1'b0, "reference kept in sleep");
    wake_ext(n);
  endtask

  task automatic t_fuse();
    int a, b, c;
    enter(SMC_MODE_PD, 4'h8, 11'h008);
    wake_ext(a);
    enter(SMC_MODE_PD, 4'h9, 11'h008);
    wake_ext(b);
    ck(b - a == PDB, "power-down start-up");
    enter(SMC_MODE_SB, 4'hb, 11'h008);
    ck(main_osc_en === 1'b1, "standby oscillator");
    wake_ext(c);
    enter(SMC_MODE_SB, 4'h3, 11'h008);
    ck(main_osc_en === 1'b0, "no crystal, power-down");
    wake_ext(b);
    ck(b - a == 7 * PDB && c - a == 4, "wake delays");
  endtask

  task automatic t_edge();
    int n;
    enter(SMC_MODE_PD, 4'h8, 11'h428);
    ext_irq_line_a <= 1'b0;
    repeat (30) @(posedge pclk);
    ck(core_clock_en === 1'b0, "edge sense woke");
    ext_irq_line_a <= 1'b1;
    pin_change_in[3] <= 1'b1;
    wait_core(n);
    ck(n < 10, "pin change wake");
    enter(SMC_MODE_SB, 4'h8, 11'h008);
    universal_serial_unit_start <= 1'b1;
    wait_core(n);
    universal_serial_unit_start <= 1'b0;
    ck(n < 10, "serial start wake");
  endtask

  task automatic t_src();
    int n;
    enter(SMC_MODE_NR, 4'h8, 11'h008);
    other_io_irq <= 1'b1;
    repeat (10) @(posedge pclk);
    ck(core_clock_en === 1'b0, "io event woke noise reduction");
    other_io_irq <= 1'b0;
    converter_done <= 1'b1;
    wait_core(n);
    converter_done <= 1'b0;
    ck(n < 5, "converter done wake");
    enter(SMC_MODE_SB, 4'h8, 11'h008);
    eeprom_ready <= 1'b1;
    repeat (10) @(posedge pclk);
    ck(core_clock_en === 1'b0, "eeprom woke standby");
    eeprom_ready <= 1'b0;
    wake_ext(n);
    enter(SMC_MODE_IDLE, 4'h8, 11'h000);
    other_io_irq <= 1'b1;
    wait_core(n);
    other_io_irq <= 1'b0;
    ck(n < 5, "io event wake idle");
  endtask

  task automatic t_abort();
    int         n;
    logic [7:0] t0;
    wr(SMC_ISTAT_OFS, 32'h7);
    wr(SMC_IMASK_OFS, 32'h4);
    enter(SMC_MODE_PD, 4'hb, 11'h008);
    t0 = taken;
    ext_irq_line_a <= 1'b0;
    repeat (5) @(posedge pclk);
    ext_irq_line_a <= 1'b1;
    wait_core(n);
    ck(taken === t0, "aborted wake served");
    apb(1'b0, SMC_ISTAT_OFS, 32'h0);
    ck(rd === 32'h7 && irq === 1'b1, "abort flagged");
    wr(SMC_IMASK_OFS, 32'h0);
    repeat (3) @(posedge pclk);
    ck(irq === 1'b0, "masked interrupt");
    wr(SMC_IMASK_OFS, 32'h4);
    wr(SMC_ISTAT_OFS, 32'h4);
    apb(1'b0, SMC_ISTAT_OFS, 32'h0);
    ck(rd === 32'h3 && irq === 1'b0, "status cleared");
  endtask

  // =========
  // main sequence
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_modes();
    t_conv();
    t_fuse();
    t_edge();
    t_src();
    t_abort();
    finish_test();
  end
endmodule
